// [src/spfc_top.sv]
// Contract
// - six 8-bit port traffic control registers, indices 00h to 05h.
// - bits 7:5 hold software's spanning-tree state; codes 110-111 unused.
// - spanning-tree state resets to 000 unmanaged, 001 managed, from strap.
// - port bit 1 set disables that port's mac transmit; resets 0.
// - port bit 0 set disables that port's mac receive; resets 0.
// - mgmt bit 4 passes table-hit unicast to fmp management port; resets 0.
// - with bit 4 clear only mirror-qualified unicast reaches fmp.
// - unicast enable ignored unless management port is the fmp.
// - mgmt bit 3 passes flooded multicast; else only mirrored multicast.
// - mgmt bit 2 passes broadcast to fmp management port; resets 0.
// - mode bit 1 gates all forwarding; resets to strap value.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module spfc_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic                                    clk_i,
  input  wire logic                                    resetn_i,
  // axi4-lite write address
  input  wire logic                                    s_axi_awvalid,
  output logic                                         s_axi_awready,
  input  wire logic [ADDR_W-1:0]                       s_axi_awaddr,
  input  wire logic [2:0]                              s_axi_awprot,
  // axi4-lite write data
  input  wire logic                                    s_axi_wvalid,
  output logic                                         s_axi_wready,
  input  wire logic [31:0]                             s_axi_wdata,
  input  wire logic [3:0]                              s_axi_wstrb,
  // axi4-lite write response
  output logic                                         s_axi_bvalid,
  input  wire logic                                    s_axi_bready,
  output logic [1:0]                                   s_axi_bresp,
  // axi4-lite read address
  input  wire logic                                    s_axi_arvalid,
  output logic                                         s_axi_arready,
  input  wire logic [ADDR_W-1:0]                       s_axi_araddr,
  input  wire logic [2:0]                              s_axi_arprot,
  // axi4-lite read data
  output logic                                         s_axi_rvalid,
  input  wire logic                                    s_axi_rready,
  output logic [31:0]                                  s_axi_rdata,
  output logic [1:0]                                   s_axi_rresp,
  // strap pin and datapath side
  input  wire logic                                    forwarding_strap_i,
  input  wire logic                                    mgmt_is_fmp_i,
  input  wire spfc_pkg::spfc_frame_t                   frame_i,
  output spfc_pkg::spfc_port_ctrl_t [spfc_pkg::NUM_PORTS-1:0] port_ctrl_o,
  output spfc_pkg::spfc_accept_t                       mgmt_accept_o,
  output logic                                         forwarding_enable_o,
  output logic                                         managed_mode_o,
  output logic                                         init_done_o,
  output logic                                         decision_valid_o,
  output logic                                         to_mgmt_o,
  output logic                                         forward_ok_o
);
  import spfc_pkg::*;

  typedef enum logic [1:0] {
    INIT_SETTLE = 2'b00,
    INIT_LOAD   = 2'b01,
    INIT_DONE   = 2'b10
  } spfc_init_t;

  spfc_init_t                init_q;
  logic [2:0]                settle_q;
  logic                      strap_lvl;
  logic                      load_defaults;

  logic                      aw_have_q;
  logic                      w_have_q;
  logic [ADDR_W-1:0]         awaddr_q;
  logic [7:0]                wbyte_q;
  logic                      wlane_q;
  logic                      commit;
  logic                      commit_hit;
  logic [5:0]                commit_idx;
  logic                      aw_take;
  logic                      w_take;
  logic                      b_done;
  logic                      aw_have_d;
  logic                      w_have_d;
  logic                      bvalid_d;
  logic                      ar_take;
  logic                      r_done;
  logic                      rvalid_d;

  spfc_port_ctrl_t [NUM_PORTS-1:0] port_q;
  spfc_accept_t              accept_q;
  logic                      fwd_en_q;
  logic                      managed_q;

  // index from a byte address; low two bits ignored
  function automatic logic [5:0] addr_index(input logic [ADDR_W-1:0] addr);
    addr_index = 6'(addr[ADDR_W-1:2]);
  endfunction

  // true when the index names an implemented register
  function automatic logic addr_hit(input logic [5:0] idx);
    addr_hit = (idx <= IDX_PORT_LAST) || (idx == IDX_MGMT) || (idx == IDX_MODE);
  endfunction

  // read image of a register; reserved bits at their defaults
  function automatic logic [7:0] read_image(input logic [5:0] idx,
                                            input spfc_port_ctrl_t [NUM_PORTS-1:0] ports,
                                            input spfc_accept_t acc,
                                            input logic fen,
                                            input logic mgd);
    logic [7:0] v;
    v = 8'h00;
    if (idx <= IDX_PORT_LAST) begin
      v[7:STP_LSB]   = ports[idx[2:0]].stp;
      v[TXDIS_BIT]   = ports[idx[2:0]].tx_disable;
      v[RXDIS_BIT]   = ports[idx[2:0]].rx_disable;
    end else if (idx == IDX_MGMT) begin
      v[UCAST_BIT]   = acc.ucast;
      v[MCAST_BIT]   = acc.mcast;
      v[BCAST_BIT]   = acc.bcast;
    end else if (idx == IDX_MODE) begin
      v[7:MODE_RSVD_LSB] = MODE_RSVD_VAL;
      v[FWD_EN_BIT]  = fen;
      v[MODE_BIT]    = mgd;
    end
    read_image = v;
  endfunction

  // strap pin through the three-stage synchroniser
  spfc_sync3 u_strap_sync (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .async_i  (forwarding_strap_i),
    .level_o  (strap_lvl)
  );

  // wait for the strap to settle, then load defaults once
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      init_q   <= INIT_SETTLE;
      settle_q <= 3'h0;
    end else begin
      case (init_q)
        INIT_SETTLE: begin
          settle_q <= settle_q + 3'h1;
          if (settle_q == STRAP_SETTLE) begin
            init_q <= INIT_LOAD;
          end
        end
        INIT_LOAD: begin
          init_q <= INIT_DONE;
        end
        INIT_DONE: begin
          init_q <= INIT_DONE;
        end
        default: begin
          init_q <= INIT_SETTLE;
        end
      endcase
    end
  end

  assign load_defaults = (init_q == INIT_LOAD);

  // handshakes on each channel
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take  = s_axi_wvalid & s_axi_wready;
  assign b_done  = s_axi_bvalid & s_axi_bready;
  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign r_done  = s_axi_rvalid & s_axi_rready;

  // write fires once address and data are both held
  assign commit     = aw_have_q & w_have_q & ~s_axi_bvalid;
  assign commit_idx = addr_index(awaddr_q);
  assign commit_hit = commit & addr_hit(commit_idx) & wlane_q;

  // next-state of the write channel bookkeeping
  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d  = w_have_q;
    bvalid_d  = s_axi_bvalid;
    if (aw_take) begin
      aw_have_d = 1'b1;
    end
    if (w_take) begin
      w_have_d = 1'b1;
    end
    if (commit) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
    end else if (b_done) begin
      bvalid_d  = 1'b0;
    end
  end

  // address and data latches; either order accepted
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= '0;
      wbyte_q   <= 8'h00;
      wlane_q   <= 1'b0;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      if (aw_take) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        wbyte_q <= s_axi_wdata[7:0];
        wlane_q <= s_axi_wstrb[0];
      end
    end
  end

  // write response and readies
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_bvalid  <= bvalid_d;
      if (commit) begin
        s_axi_bresp <= addr_hit(commit_idx) ? RESP_OKAY : RESP_SLVERR;
      end
      s_axi_awready <= (init_q == INIT_DONE) & ~aw_have_d & ~bvalid_d;
      s_axi_wready  <= (init_q == INIT_DONE) & ~w_have_d & ~bvalid_d;
    end
  end

  // read channel: one read in flight
  assign rvalid_d = ar_take | (s_axi_rvalid & ~r_done);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_rvalid  <= rvalid_d;
      s_axi_arready <= (init_q == INIT_DONE) & ~rvalid_d;
      if (ar_take) begin
        s_axi_rdata <= {24'h00_0000, read_image(addr_index(s_axi_araddr), port_q,
                                                accept_q, fwd_en_q, managed_q)};
        s_axi_rresp <= addr_hit(addr_index(s_axi_araddr)) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // per-port traffic control registers
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        port_q[p].stp        <= STP_NONE;
        port_q[p].tx_disable <= TXDIS_RST;
        port_q[p].rx_disable <= RXDIS_RST;
      end else if (load_defaults) begin
        port_q[p].stp        <= strap_lvl ? STP_NONE : STP_DISABLED;
        port_q[p].tx_disable <= TXDIS_RST;
        port_q[p].rx_disable <= RXDIS_RST;
      end else if (commit_hit && commit_idx == IDX_PORT_FIRST + 6'(p)) begin
        port_q[p].stp        <= wbyte_q[7:STP_LSB];
        port_q[p].tx_disable <= wbyte_q[TXDIS_BIT];
        port_q[p].rx_disable <= wbyte_q[RXDIS_BIT];
      end
    end
  end

  // management port receive control
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      accept_q <= {ACCEPT_RST, ACCEPT_RST, ACCEPT_RST};
    end else if (commit_hit && commit_idx == IDX_MGMT) begin
      accept_q.ucast <= wbyte_q[UCAST_BIT];
      accept_q.mcast <= wbyte_q[MCAST_BIT];
      accept_q.bcast <= wbyte_q[BCAST_BIT];
    end
  end

  // switch mode; forwarding held off until the strap is known
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fwd_en_q  <= 1'b0;
      managed_q <= 1'b0;
    end else if (load_defaults) begin
      fwd_en_q  <= strap_lvl;
      managed_q <= ~strap_lvl;
    end else if (commit_hit && commit_idx == IDX_MODE) begin
      fwd_en_q  <= wbyte_q[FWD_EN_BIT];
      managed_q <= wbyte_q[MODE_BIT];
    end
  end

  // control outputs, registered copies
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      port_ctrl_o         <= '0;
      mgmt_accept_o       <= '0;
      forwarding_enable_o <= 1'b0;
      managed_mode_o      <= 1'b0;
      init_done_o         <= 1'b0;
    end else begin
      port_ctrl_o         <= port_q;
      mgmt_accept_o       <= accept_q;
      forwarding_enable_o <= fwd_en_q;
      managed_mode_o      <= managed_q;
      init_done_o         <= (init_q == INIT_DONE);
    end
  end

  // per-frame steering toward the management port
  spfc_mgmt_filter u_filter (
    .clk_i            (clk_i),
    .resetn_i         (resetn_i),
    .frame_i          (frame_i),
    .accept_i         (accept_q),
    .mgmt_is_fmp_i    (mgmt_is_fmp_i),
    .fwd_enable_i     (fwd_en_q),
    .managed_i        (managed_q),
    .decision_valid_o (decision_valid_o),
    .to_mgmt_o        (to_mgmt_o),
    .forward_ok_o     (forward_ok_o)
  );

endmodule

// [src/spfc_pkg.sv]
package spfc_pkg;

  // register indices as printed; byte address is four times the index
  localparam int          NUM_PORTS       = 6;
  localparam logic [5:0]  IDX_PORT_FIRST  = 6'h00;
  localparam logic [5:0]  IDX_PORT_LAST   = 6'h05;
  localparam logic [5:0]  IDX_MGMT        = 6'h08;
  localparam logic [5:0]  IDX_MODE        = 6'h0b;

  // port traffic control fields
  localparam int          STP_LSB         = 5;
  localparam int          TXDIS_BIT       = 1;
  localparam int          RXDIS_BIT       = 0;
  // management port receive control fields
  localparam int          UCAST_BIT       = 4;
  localparam int          MCAST_BIT       = 3;
  localparam int          BCAST_BIT       = 2;
  // switch mode fields
  localparam int          FWD_EN_BIT      = 1;
  localparam int          MODE_BIT        = 0;
  localparam int          MODE_RSVD_LSB   = 2;

  // reset values
  localparam logic        TXDIS_RST       = 1'b0;
  localparam logic        RXDIS_RST       = 1'b0;
  localparam logic        ACCEPT_RST      = 1'b0;
  localparam logic [5:0]  MODE_RSVD_VAL   = 6'h01;

  // last settle count; the strap is given this many cycles plus one to settle after reset release
  localparam logic [2:0]  STRAP_SETTLE    = 3'h4;

  // axi responses
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  typedef enum logic [2:0] {
    STP_NONE       = 3'b000,
    STP_DISABLED   = 3'b001,
    STP_BLOCKING   = 3'b010,
    STP_LISTENING  = 3'b011,
    STP_LEARNING   = 3'b100,
    STP_FORWARDING = 3'b101
  } spfc_stp_t;

  typedef struct packed {
    logic [2:0] stp;
    logic       tx_disable;
    logic       rx_disable;
  } spfc_port_ctrl_t;

  typedef struct packed {
    logic ucast;
    logic mcast;
    logic bcast;
  } spfc_accept_t;

  typedef struct packed {
    logic valid;
    logic unicast;
    logic multicast;
    logic broadcast;
    logic table_hit;
    logic flooded;
    logic mirror_hit;
    logic reserved_mcast;
  } spfc_frame_t;

endpackage

// [src/spfc_sync3.sv]
`timescale 1ns/1ps
module spfc_sync3 (
  input  wire logic clk_i,
  input  wire logic resetn_i,
  input  wire logic async_i,
  output logic      level_o
);

  logic [2:0] stage_q;

  // three-stage chain; first stage feeds only the second
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stage_q <= 3'h0;
    end else begin
      stage_q <= {stage_q[1:0], async_i};
    end
  end

  // level moves only when stages two and three agree
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      level_o <= 1'b0;
    end else if (stage_q[1] == stage_q[2]) begin
      level_o <= stage_q[2];
    end
  end

endmodule

// [src/spfc_mgmt_filter.sv]
`timescale 1ns/1ps
module spfc_mgmt_filter (
  input  wire logic                  clk_i,
  input  wire logic                  resetn_i,
  input  wire spfc_pkg::spfc_frame_t frame_i,
  input  wire spfc_pkg::spfc_accept_t accept_i,
  input  wire logic                  mgmt_is_fmp_i,
  input  wire logic                  fwd_enable_i,
  input  wire logic                  managed_i,
  output logic                       decision_valid_o,
  output logic                       to_mgmt_o,
  output logic                       forward_ok_o
);
  import spfc_pkg::*;

  logic go;
  logic uc_sel;
  logic mc_sel;
  logic bc_sel;
  logic rsvd_trap;

  // no frame goes to management or forwarding while forwarding is off
  assign go = frame_i.valid & fwd_enable_i;
  // unicast: table hit when accepted, else mirror only; needs fmp role
  assign uc_sel = frame_i.unicast & mgmt_is_fmp_i
                & ((accept_i.ucast & frame_i.table_hit) | frame_i.mirror_hit);
  // multicast: flooded when accepted, else mirror only
  assign mc_sel = frame_i.multicast & mgmt_is_fmp_i
                & ((accept_i.mcast & frame_i.flooded) | frame_i.mirror_hit);
  // broadcast: all when accepted, else mirror only
  assign bc_sel = frame_i.broadcast & mgmt_is_fmp_i
                & (accept_i.bcast | frame_i.mirror_hit);
  // managed mode keeps reserved multicast from flooding; it reaches the cpu only when mgmt_is_fmp_i is set
  assign rsvd_trap = managed_i & frame_i.reserved_mcast;

  // one registered decision per presented frame
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      decision_valid_o <= 1'b0;
      to_mgmt_o        <= 1'b0;
      forward_ok_o     <= 1'b0;
    end else begin
      decision_valid_o <= frame_i.valid;
      to_mgmt_o        <= go & (uc_sel | mc_sel | bc_sel | (rsvd_trap & mgmt_is_fmp_i));
      forward_ok_o     <= go & ~rsvd_trap;
    end
  end

endmodule

// [tb/spfc_top_properties.sv]
`timescale 1ns/1ps
module spfc_top_properties (
  input wire logic                                             clk_i,
  input wire logic                                             resetn_i,
  input wire logic                                             s_axi_bvalid,
  input wire logic                                             s_axi_bready,
  input wire logic [1:0]                                       s_axi_bresp,
  input wire logic                                             s_axi_rvalid,
  input wire logic [31:0]                                      s_axi_rdata,
  input wire logic                                             forwarding_strap_i,
  input wire logic                                             mgmt_is_fmp_i,
  input wire spfc_pkg::spfc_frame_t                            frame_i,
  input wire spfc_pkg::spfc_port_ctrl_t [spfc_pkg::NUM_PORTS-1:0] port_ctrl_o,
  input wire spfc_pkg::spfc_accept_t                           mgmt_accept_o,
  input wire logic                                             forwarding_enable_o,
  input wire logic                                             managed_mode_o,
  input wire logic                                             init_done_o,
  input wire logic                                             decision_valid_o,
  input wire logic                                             to_mgmt_o,
  input wire logic                                             forward_ok_o
);
  import spfc_pkg::*;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  // register width and strap defaults
  a_read_width: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data above bit 7 not zero");
  a_strap_stp: assert property ($rose(init_done_o) |-> ##2
    (port_ctrl_o[0].stp == {2'b00, !forwarding_strap_i} && port_ctrl_o[5].stp == {2'b00, !forwarding_strap_i}))
    else $error("spanning tree default wrong");
  a_strap_mode: assert property ($rose(init_done_o) |-> ##2
    (forwarding_enable_o == forwarding_strap_i && managed_mode_o != forwarding_strap_i))
    else $error("forwarding or mode default wrong");
  // frame decisions against the settings
  a_fwd_gate: assert property ((!forwarding_enable_o)[*3] ##0 decision_valid_o |-> !to_mgmt_o && !forward_ok_o)
    else $error("frame passed with forwarding off");
  a_fmp_ignore: assert property (frame_i.valid && !mgmt_is_fmp_i |=> decision_valid_o && !to_mgmt_o)
    else $error("frame to management port while not fmp");
  a_ucast_hit: assert property ((forwarding_enable_o && mgmt_accept_o.ucast)[*3] ##0
    (frame_i.valid && frame_i.unicast && frame_i.table_hit && mgmt_is_fmp_i) |=> to_mgmt_o)
    else $error("table hit unicast not passed");
  a_ucast_mirror: assert property (forwarding_enable_o[*3] ##0
    (frame_i.valid && frame_i.unicast && frame_i.mirror_hit && mgmt_is_fmp_i) |=> to_mgmt_o)
    else $error("mirrored unicast not passed");
  a_mcast_flood: assert property ((forwarding_enable_o && mgmt_accept_o.mcast)[*3] ##0
    (frame_i.valid && frame_i.multicast && frame_i.flooded && mgmt_is_fmp_i) |=> to_mgmt_o)
    else $error("flooded multicast not passed");
  a_bcast_pass: assert property ((forwarding_enable_o && mgmt_accept_o.bcast)[*3] ##0
    (frame_i.valid && frame_i.broadcast && mgmt_is_fmp_i) |=> to_mgmt_o)
    else $error("broadcast not passed");
  a_rsvd_trap: assert property (managed_mode_o[*3] ##0 (frame_i.valid && frame_i.reserved_mcast) |=> !forward_ok_o)
    else $error("reserved multicast flooded in managed mode");

  // main scenarios reached
  c_slverr: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h2);
  c_to_mgmt: cover property (decision_valid_o && to_mgmt_o);
  c_init: cover property ($rose(init_done_o));
endmodule

// [tb/test_switch_port_forwarding_control.sv]
`timescale 1ns/1ps
module test_switch_port_forwarding_control;
  import spfc_pkg::*;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic clk_i = 1'b0, resetn_i = 1'b0, forwarding_strap_i = 1'b1, mgmt_is_fmp_i = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'h0;
  spfc_frame_t frame_i = '0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rdv;
  logic        forwarding_enable_o, managed_mode_o, init_done_o, decision_valid_o, to_mgmt_o, forward_ok_o;
  spfc_port_ctrl_t [NUM_PORTS-1:0] port_ctrl_o;
  spfc_accept_t mgmt_accept_o;
  int          miscompares = 0;
  int          comparisons = 0;
  int          cycles = 0;

  spfc_top #(.ADDR_W(8)) dut (.clk_i, .resetn_i, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .forwarding_strap_i, .mgmt_is_fmp_i,
    .frame_i, .port_ctrl_o, .mgmt_accept_o, .forwarding_enable_o, .managed_mode_o, .init_done_o,
    .decision_valid_o, .to_mgmt_o, .forward_ok_o);

  // 50 ns clock
  initial forever #25 clk_i = ~clk_i;

  // hang guard
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      close_out();
    end
  end

  task automatic close_out;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one write, address and data offered together
  task automatic wchk(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s, input logic [1:0] er);
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    s_axi_bready <= 1'b0;
  endtask

  // one read, held until the data is taken
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rdv = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk("rdata", e, rdv);
    chk("rresp", {30'h0, RESP_OKAY}, {30'h0, rsp});
  endtask

  // one frame, decision seen the cycle after it is taken
  task automatic frm(input logic [7:0] f, input logic fmp, input logic tm, input logic ok);
    @(posedge clk_i);
    frame_i <= f;
    mgmt_is_fmp_i <= fmp;
    @(posedge clk_i);
    frame_i <= '0;
    @(posedge clk_i);
    chk("decision_valid_o", 32'h1, {31'h0, decision_valid_o});
    chk("to_mgmt_o", {31'h0, tm}, {31'h0, to_mgmt_o});
    chk("forward_ok_o", {31'h0, ok}, {31'h0, forward_ok_o});
  endtask

  task automatic do_reset(input logic st);
    @(posedge clk_i);
    resetn_i <= 1'b0;
    forwarding_strap_i <= st;
    repeat (4) @(posedge clk_i);
    chk("init_done_o", 32'h0, {31'h0, init_done_o});
    resetn_i <= 1'b1;
    while (!(init_done_o === 1'b1 && s_axi_arready === 1'b1)) begin
      @(posedge clk_i);
    end
  endtask

  // strap defaults both ways, then register and frame scenarios
  initial begin
    for (int st = 1; st >= 0; st--) begin
      do_reset(st[0]);
      for (int p = 0; p < NUM_PORTS; p++) begin
        rchk(8'(p * 4), st ? 32'h00 : 32'h20);
        chk("port_ctrl_o", st ? 32'h0 : 32'h4, {27'h0, port_ctrl_o[p]});
      end
      rchk(8'h20, 32'h00);
      rchk(8'h2c, st ? 32'h06 : 32'h05);
      chk("mode outputs", {30'h0, st[0], ~st[0]}, {30'h0, forwarding_enable_o, managed_mode_o});
    end
    for (int p = 0; p < NUM_PORTS; p++) wchk(8'(p * 4), 8'(p * 32 + 28 + p % 4), 4'h1, RESP_OKAY);
    for (int p = 0; p < NUM_PORTS; p++) begin
      rchk(8'(p * 4), 32'(p * 32 + p % 4));
      chk("port_ctrl_o", 32'(p * 4 + p % 4), {27'h0, port_ctrl_o[p]});
    end
    wchk(8'h00, 8'hff, 4'h0, RESP_OKAY);
    rchk(8'h00, 32'h00);
    wchk(8'h18, 8'hff, 4'h1, RESP_SLVERR);
    rd(8'h24);
    chk("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    chk("unmapped rdata", 32'h0, rdv);
    wchk(8'h2c, 8'hff, 4'h1, RESP_OKAY);
    rchk(8'h2c, 32'h07);
    wchk(8'h20, 8'hff, 4'h1, RESP_OKAY);
    rchk(8'h20, 32'h1c);
    chk("mgmt_accept_o", 32'h7, {29'h0, mgmt_accept_o});
    frm(8'b1100_1000, 1'b1, 1'b1, 1'b1);
    frm(8'b1100_1000, 1'b0, 1'b0, 1'b1);
    frm(8'b1010_0100, 1'b1, 1'b1, 1'b1);
    frm(8'b1001_0000, 1'b1, 1'b1, 1'b1);
    frm(8'b1010_0001, 1'b0, 1'b0, 1'b0);
    frm(8'b1010_0001, 1'b1, 1'b1, 1'b0);
    wchk(8'h2c, 8'h02, 4'h1, RESP_OKAY);
    frm(8'b1010_0001, 1'b0, 1'b0, 1'b1);
    wchk(8'h20, 8'h00, 4'h1, RESP_OKAY);
    frm(8'b1100_1000, 1'b1, 1'b0, 1'b1);
    frm(8'b1100_0010, 1'b1, 1'b1, 1'b1);
    frm(8'b1010_0100, 1'b1, 1'b0, 1'b1);
    frm(8'b1010_0010, 1'b1, 1'b1, 1'b1);
    frm(8'b1001_0000, 1'b1, 1'b0, 1'b1);
    frm(8'b1001_0010, 1'b1, 1'b1, 1'b1);
    wchk(8'h2c, 8'h01, 4'h1, RESP_OKAY);
    frm(8'b1100_0010, 1'b1, 1'b0, 1'b0);
    chk("forwarding_enable_o", 32'h0, {31'h0, forwarding_enable_o});
    close_out();
  end
endmodule

bind spfc_top spfc_top_properties u_props (.clk_i, .resetn_i, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_rvalid, .s_axi_rdata, .forwarding_strap_i, .mgmt_is_fmp_i, .frame_i, .port_ctrl_o, .mgmt_accept_o,
  .forwarding_enable_o, .managed_mode_o, .init_done_o, .decision_valid_o, .to_mgmt_o, .forward_ok_o);
